//--- src/debug_link_host.sv
// host-side instruction sequencer for the single-wire debug link
// What this block does
// R1: opcode in instruction bits 7..5, eight kinds
// R2: address size 1, 2, 3 bytes; 11 reserved
// R3: data size 1 or 2 bytes; 1x reserved
// R4: key size 8/16 bytes; select key or info
// R5: direct load sends address then awaits data
// R6: direct repeats resend full address every time
// R7: device handles addresses up to 24 bits
// R8: direct store: address, ack, data, ack
// R9: indirect load reads pointer target or pointer
// R10: pointer load: indirect store, address, ack
// R11: indirect store writes data, acks, may increment
// R12: repeated store frames only after prior ack
// R13: control/status load returns exactly one byte
// R14: control/status store: one byte, no answer
// R15: repeat count n runs next instruction n+1
// R16: repeats skip header; no repeat of repeat
// R17: only a break aborts a repeat run
// R18: repeat value width follows data size
// R19: training char before every non-implicit instruction
// R20: host waits any delay for device answers
// R21: device inserts guard idle bits before answers
// R22: device error state ignores all but break
// R23: reserved encodings count as protocol error
`timescale 1ns/10ps
`default_nettype none
module debug_link_host
	import debug_link_pkg::*;
#(
	parameter logic [7:0] TRAIN_CHAR = 8'h55, // training pattern, alternating bits
	parameter logic [7:0] ACK_CHAR   = 8'h40  // acknowledge character value
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// characters toward the line phy
	output logic             link_tx_valid,
	output link_tx_s         link_tx,
	input  wire logic        link_tx_ready,
	// characters from the line phy
	input  wire logic        link_rx_valid,
	input  wire logic [7:0]  link_rx_data,
	// status
	output logic             busy
);
	// software-visible registers
	logic [7:0]  instr_reg_ff;  // instruction byte for the next header
	logic [31:0] addr_ff;       // address operand, low byte first on the wire
	logic [31:0] wdata_ff;      // store data, repeat count or key low half
	logic [31:0] rdata_ff;      // returned bytes, byte i at lane i mod 4
	logic [31:0] prdata_ff;     // read data captured in the setup phase
	logic        pslverr_ff;    // error answer captured in the setup phase
	logic        start_pend_ff; // start request waiting for idle
	logic        brk_pend_ff;   // break request waiting for the line
	// sequencer state
	state_e      st_ff, nxt_st;
	logic [7:0]  instr_ff;      // instruction latched for the whole run
	logic [4:0]  cnt_ff;        // byte index inside the current phase
	logic        tx_valid_ff;
	link_tx_s    tx_ff;
	logic        err_ff, nack_ff, refused_ff;
	logic [7:0]  rpt_left_ff;   // implicit iterations still owed
	logic        rpt_first_ff;  // next start is the first repeated one
	logic        rpt_run_ff;    // a repeat run is in progress
	// apb decode
	wire apb_setup = psel && !penable;
	wire apb_wr    = psel && penable && pwrite;
	wire hit_ctrl  = paddr == OFS_CTRL;
	wire hit_instr = paddr == OFS_INSTR;
	wire hit_addr  = paddr == OFS_ADDR;
	wire hit_wdata = paddr == OFS_WDATA;
	wire hit_rdata = paddr == OFS_RDATA;
	wire hit_stat  = paddr == OFS_STATUS;
	wire hit_any   = hit_ctrl || hit_instr || hit_addr || hit_wdata || hit_rdata || hit_stat;
	// status word
	wire implicit = rpt_run_ff && (rpt_left_ff != RST_COUNT); // [R16]
	wire [31:0] status_word = {16'h0000, rpt_left_ff, 2'b00, implicit, rpt_run_ff,
		refused_ff, nack_ff, err_ff, busy};
	// read mux, selected by address priority chain
	logic [31:0] rd_mux;
	always_comb begin
		if (hit_instr) begin
			rd_mux = {24'h00_0000, instr_reg_ff};
		end else if (hit_addr) begin
			rd_mux = addr_ff;
		end else if (hit_wdata) begin
			rd_mux = wdata_ff;
		end else if (hit_rdata) begin
			rd_mux = rdata_ff;
		end else if (hit_stat) begin
			rd_mux = status_word;
		end else begin
			rd_mux = RST_WORD; // control and unmapped read as zero
		end
	end
	// instruction fields, taken from the software copy before a header run
	wire [7:0] instr_cur = (st_ff == S_IDLE && !implicit) ? instr_reg_ff : instr_ff;
	wire op_e  op        = op_e'(instr_cur[OP_MSB:OP_LSB]); // [R1]
	wire ind       = op == OP_LOAD_INDIRECT || op == OP_STORE_INDIRECT;
	wire [1:0] sz_a    = ind ? instr_cur[1:0] : instr_cur[3:2]; // [R2]
	wire [1:0] sz_b    = instr_cur[1:0]; // [R3] [R18]
	wire [1:0] ptr_fld = instr_cur[3:2];
	wire ptr_reg   = ind && ptr_fld == PTR_REG; // [R9] [R10]
	wire sib_sel   = instr_cur[SIB_BIT]; // [R4]
	// reserved encodings are refused before anything goes on the line
	wire bad_direct = (op == OP_LOAD_DIRECT || op == OP_STORE_DIRECT) && (sz_a == SZ_RESERVED || sz_b[1]);
	wire bad_ind    = ind && (ptr_fld == PTR_RES || (ptr_reg ? sz_a == SZ_RESERVED : sz_b[1]));
	wire bad_rpt    = op == OP_REPEAT && (sz_b[1] || rpt_first_ff); // [R16]
	wire bad_key    = op == OP_KEY_INFO && sz_b[1]; // [R4]
	wire bad_instr  = bad_direct || bad_ind || bad_rpt || bad_key; // [R23]
	// phase plan of the instruction
	wire has_addr = op == OP_LOAD_DIRECT || op == OP_STORE_DIRECT ||
		(op == OP_STORE_INDIRECT && ptr_reg); // [R5] [R6] [R10]
	wire rx_op    = op == OP_LOAD_DIRECT || op == OP_LOAD_INDIRECT ||
		op == OP_LOAD_CTRL_STATUS || (op == OP_KEY_INFO && sib_sel);
	wire is_cs    = op == OP_LOAD_CTRL_STATUS || op == OP_STORE_CTRL_STATUS;
	wire [4:0] n_addr = {3'b000, sz_a} + 5'h01;
	wire [4:0] n_data = is_cs ? CS_BYTES : // [R13] [R14]
		(op == OP_KEY_INFO) ? (sz_b[0] ? KEY_BYTES_128 : KEY_BYTES_64) : // [R4]
		({3'b000, sz_b} + 5'h01); // [R3]
	wire last_addr = cnt_ff == n_addr - 5'h01;
	wire last_data = cnt_ff == n_data - 5'h01;
	wire state_e ph0 = has_addr ? S_ADDR : (rx_op ? S_RDAT : S_WDAT);
	// handshakes
	wire tx_fire  = tx_valid_ff && link_tx_ready;
	wire start_go = start_pend_ff && st_ff == S_IDLE && !brk_pend_ff && !err_ff && !bad_instr;
	wire start_bad = start_pend_ff && st_ff == S_IDLE && !brk_pend_ff && !err_ff && bad_instr;
	wire ack_ok   = link_rx_valid && link_rx_data == ACK_CHAR;
	wire in_ack   = st_ff == S_ACK1 || st_ff == S_ACK2;
	wire nack     = in_ack && link_rx_valid && link_rx_data != ACK_CHAR;
	wire want_tx  = st_ff == S_TRAIN || st_ff == S_INSTR || st_ff == S_ADDR || st_ff == S_WDAT ||
		st_ff == S_BRK;
	wire brk_done = st_ff == S_BRK && tx_fire;
	wire finish   = nxt_st == S_IDLE && st_ff != S_IDLE && st_ff != S_BRK;
	// next state; answers are awaited for as long as they take
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			S_IDLE: begin
				if (brk_pend_ff) begin
					nxt_st = S_BRK;
				end else if (start_go) begin
					nxt_st = implicit ? ph0 : S_TRAIN; // [R16] [R19]
				end
			end
			S_TRAIN: if (tx_fire) begin
				nxt_st = S_INSTR;
			end
			S_INSTR: if (tx_fire) begin
				nxt_st = ph0;
			end
			S_ADDR: if (tx_fire && last_addr) begin
				nxt_st = (op == OP_LOAD_DIRECT) ? S_RDAT : S_ACK1; // [R5] [R8] [R10]
			end
			S_ACK1: if (link_rx_valid) begin
				nxt_st = (ack_ok && op == OP_STORE_DIRECT) ? S_WDAT : S_IDLE; // [R8] [R20]
			end
			S_WDAT: if (tx_fire && last_data) begin
				nxt_st = (op == OP_STORE_DIRECT || op == OP_STORE_INDIRECT) ? S_ACK2 : S_IDLE; // [R11] [R14]
			end
			S_ACK2: if (link_rx_valid) begin
				nxt_st = S_IDLE; // [R12]
			end
			S_RDAT: if (link_rx_valid && last_data) begin
				nxt_st = S_IDLE; // [R13] [R21]
			end
			S_BRK: if (tx_fire) begin
				nxt_st = S_IDLE;
			end
			default: nxt_st = S_IDLE;
		endcase
		// a break request interrupts any phase once no character is on offer
		if (brk_pend_ff && !tx_valid_ff && st_ff != S_BRK) begin
			nxt_st = S_BRK; // [R17]
		end
	end
	// byte to offer next
	wire [63:0] key_src = {addr_ff, wdata_ff};
	link_tx_s   tx_next;
	always_comb begin
		tx_next.brk  = 1'b0;
		tx_next.data = TRAIN_CHAR; // [R19]
		case (st_ff)
			S_INSTR: tx_next.data = instr_ff;
			S_ADDR:  tx_next.data = addr_ff[{cnt_ff[1:0], 3'b000} +: 8]; // [R6]
			S_WDAT:  tx_next.data = (op == OP_KEY_INFO) ? key_src[{cnt_ff[2:0], 3'b000} +: 8] :
				wdata_ff[{cnt_ff[1:0], 3'b000} +: 8];
			S_BRK: begin
				tx_next.brk  = 1'b1;
				tx_next.data = 8'h00;
			end
			default: tx_next.data = TRAIN_CHAR;
		endcase
	end
	// apb register writes and captured read data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			instr_reg_ff <= RST_INSTR;
			addr_ff      <= RST_WORD;
			wdata_ff     <= RST_WORD;
			prdata_ff    <= RST_WORD;
			pslverr_ff   <= 1'b0;
		end else begin
			if (apb_setup) begin
				prdata_ff  <= rd_mux;
				pslverr_ff <= !hit_any;
			end
			if (apb_wr && hit_instr) instr_reg_ff <= pwdata[7:0];
			if (apb_wr && hit_addr) addr_ff <= pwdata;
			if (apb_wr && hit_wdata) wdata_ff <= pwdata;
		end
	end
	// command pulses are held until the sequencer takes them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_pend_ff <= 1'b0;
			brk_pend_ff   <= 1'b0;
		end else begin
			start_pend_ff <= (apb_wr && hit_ctrl && pwdata[CTRL_START_BIT]) ||
				(start_pend_ff && !start_go && !start_bad && !brk_done);
			brk_pend_ff   <= (apb_wr && hit_ctrl && pwdata[CTRL_BREAK_BIT]) ||
				(brk_pend_ff && st_ff != S_BRK);
		end
	end
	// sequencer registers and byte index
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff    <= S_IDLE;
			cnt_ff   <= 5'h00;
			instr_ff <= RST_INSTR;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= (nxt_st != st_ff) ? 5'h00 :
				((tx_fire || (st_ff == S_RDAT && link_rx_valid)) ? cnt_ff + 5'h01 : cnt_ff);
			if (start_go && !implicit) instr_ff <= instr_reg_ff;
		end
	end
	// output character stage; a loaded character stays until the phy takes it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_ff <= 1'b0;
			tx_ff       <= '0;
		end else if (tx_fire) begin
			tx_valid_ff <= 1'b0;
		end else if (want_tx && !tx_valid_ff && !(brk_pend_ff && st_ff != S_BRK)) begin
			tx_valid_ff <= 1'b1;
			tx_ff       <= tx_next;
		end
	end
	// returned bytes land at their lane
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= RST_WORD;
		end else if (start_go) begin
			rdata_ff <= RST_WORD;
		end else if (st_ff == S_RDAT && link_rx_valid) begin
			rdata_ff[{cnt_ff[1:0], 3'b000} +: 8] <= link_rx_data;
		end
	end
	// error flags; set wins over the break that clears them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_ff     <= 1'b0;
			nack_ff    <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			err_ff     <= nack || start_bad || (err_ff && !brk_done); // [R22] [R23]
			nack_ff    <= nack || (nack_ff && !brk_done);
			refused_ff <= start_bad || (refused_ff && !brk_done);
		end
	end
	// repeat bookkeeping: the run owes count further implicit iterations
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rpt_left_ff  <= RST_COUNT;
			rpt_first_ff <= 1'b0;
			rpt_run_ff   <= 1'b0;
		end else if (brk_done) begin
			rpt_left_ff  <= RST_COUNT; // [R17]
			rpt_first_ff <= 1'b0;
			rpt_run_ff   <= 1'b0;
		end else if (finish && op == OP_REPEAT) begin
			rpt_left_ff  <= wdata_ff[7:0]; // [R15] [R18]
			rpt_first_ff <= 1'b1;
		end else if (start_go) begin
			if (implicit) begin
				rpt_left_ff <= rpt_left_ff - 8'h01; // [R15]
			end else begin
				rpt_run_ff   <= rpt_first_ff;
				rpt_first_ff <= 1'b0;
			end
		end
	end
	// port drive
	assign prdata        = prdata_ff;
	assign pslverr       = pslverr_ff;
	assign pready        = 1'b1;
	assign link_tx_valid = tx_valid_ff;
	assign link_tx       = tx_ff;
	assign busy          = st_ff != S_IDLE;
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_ack_after_addr;
		st_ff == S_ACK1 && ack_ok && op == OP_STORE_DIRECT;
	endsequence
	a_train_first: assert property (start_go && !implicit |=> st_ff == S_TRAIN ##[1:1000] // [R19]
		(tx_fire && tx_ff.data == TRAIN_CHAR)) else $error("header did not open with training char");
	a_instr_follows: assert property (st_ff == S_TRAIN && tx_fire |=> st_ff == S_INSTR) // [R1]
		else $error("instruction byte does not follow training char");
	a_addr_length: assert property (st_ff == S_ADDR && tx_fire && last_addr |=> st_ff != S_ADDR) // [R2]
		else $error("address phase length wrong");
	a_store_ack_data: assert property (s_ack_after_addr |=> st_ff == S_WDAT) // [R8]
		else $error("store data not sent after ack");
	a_cs_no_answer: assert property (st_ff == S_WDAT && op == OP_STORE_CTRL_STATUS && tx_fire // [R14]
		|=> st_ff == S_IDLE) else $error("control store waited for an answer");
	a_rpt_countdown: assert property (start_go && implicit |=> // [R15]
		rpt_left_ff == $past(rpt_left_ff) - 8'h01 && st_ff != S_TRAIN) else $error("repeat count not consumed");
	a_break_clears: assert property (brk_done |=> !rpt_run_ff && !err_ff && rpt_left_ff == RST_COUNT) // [R17]
		else $error("break left repeat or error state");
	a_reserved_refused: assert property (start_bad |=> err_ff && refused_ff && st_ff == S_IDLE) // [R23]
		else $error("reserved encoding not refused");
	a_no_rpt_of_rpt: assert property (rpt_first_ff && st_ff == S_IDLE && op == OP_REPEAT |-> !start_go) // [R16]
		else $error("repeat instruction was repeated");
	a_tx_hold: assert property (tx_valid_ff && !link_tx_ready |=> tx_valid_ff && $stable(tx_ff))
		else $error("offered character changed before taken");
endmodule
`default_nettype wire

//--- inc/debug_link_pkg.sv
// constants, types and register map of the debug link host controller
package debug_link_pkg;

	// software register offsets on the apb side
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_INSTR  = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0c;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// control register bit positions (write-one pulses)
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_BREAK_BIT = 1;

	// reset values
	localparam logic [7:0]  RST_INSTR = 8'h00;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [7:0]  RST_COUNT = 8'h00;

	// instruction byte field positions
	localparam int OP_MSB  = 7;
	localparam int OP_LSB  = 5;
	localparam int SIB_BIT = 2;

	// field encodings
	localparam logic [1:0] SZ_RESERVED = 2'h3;
	localparam logic [1:0] PTR_REG     = 2'h2;
	localparam logic [1:0] PTR_RES     = 2'h3;

	// frame lengths in bytes
	localparam logic [4:0] CS_BYTES      = 5'h01;
	localparam logic [4:0] KEY_BYTES_64  = 5'h08;
	localparam logic [4:0] KEY_BYTES_128 = 5'h10;

	// instruction opcodes
	typedef enum logic [2:0] {
		OP_LOAD_DIRECT      = 3'h0,
		OP_LOAD_INDIRECT    = 3'h1,
		OP_STORE_DIRECT     = 3'h2,
		OP_STORE_INDIRECT   = 3'h3,
		OP_LOAD_CTRL_STATUS = 3'h4,
		OP_REPEAT           = 3'h5,
		OP_STORE_CTRL_STATUS= 3'h6,
		OP_KEY_INFO         = 3'h7
	} op_e;

	// controller sequencing states, one-hot
	typedef enum logic [8:0] {
		S_IDLE  = 9'h001,
		S_TRAIN = 9'h002,
		S_INSTR = 9'h004,
		S_ADDR  = 9'h008,
		S_ACK1  = 9'h010,
		S_WDAT  = 9'h020,
		S_ACK2  = 9'h040,
		S_RDAT  = 9'h080,
		S_BRK   = 9'h100
	} state_e;

	// one character handed to the line phy
	typedef struct packed {
		logic       brk;
		logic [7:0] data;
	} link_tx_s;

endpackage

//--- test/link_device_model.sv
// behavioural model of the debug link device at the far side
`timescale 1ns/10ps
`default_nettype none
module link_device_model
	import debug_link_pkg::*;
#(
	parameter int         GUARD = 4,    // idle cycles before an answer
	parameter logic [7:0] ACK   = 8'h40 // acknowledge character
) (
	// clock and reset
	input  wire logic     clock,
	input  wire logic     rst_n,
	// characters from the host
	input  wire logic     tx_valid,
	input  wire link_tx_s tx,
	output logic          tx_ready,
	// characters to the host
	output logic          rx_valid,
	output logic [7:0]    rx_data,
	// pacing
	input  wire logic     slow
);
	logic [7:0]  mem [256]; // data space, low address byte only
	logic [7:0]  cs [16];   // control/status space
	logic [23:0] ptr;       // address pointer
	logic [7:0]  rpt;       // repeat count
	logic [1:0]  pace;      // slow ready pacing
	logic [7:0]  c;         // last character
	logic        brk;       // last character was a break
	int          n_chars;   // characters taken
	int          n_train;   // training characters taken
	int          gap;       // answer delay, longer when slow

	// slow mode takes a character only every third cycle
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) pace <= 2'h0;
		else pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
	assign tx_ready = !slow || pace == 2'h2;
	assign gap      = slow ? GUARD * 5 : GUARD;

	// take one character
	task automatic get(output logic [7:0] v);
		do @(posedge clock); while (tx_valid !== 1'b1 || tx_ready !== 1'b1); // no take while outputs are unknown
		v = tx.data;
		brk = tx.brk;
		n_chars++;
	endtask

	// send one byte after idle cycles
	task automatic put(input logic [7:0] v, input int g);
		repeat (g) @(posedge clock);
		rx_valid <= 1'b1;
		rx_data  <= v;
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_data  <= ~v; // a released line shows no stale byte
	endtask

	// one run of an instruction, operands only
	task automatic op(input logic [7:0] i);
		int          na, nb, k;
		logic [7:0]  v;
		logic [23:0] a;
		na = int'(i[3:2]) + 1;
		nb = int'(i[1:0]) + 1;
		a  = '0;
		case (i[7:5])
		3'h0, 3'h2: begin // full address on every run
			for (k = 0; k < na; k++) begin
				get(v);
				a[8*k +: 8] = v;
			end
			if (!i[6])
				for (k = 0; k < nb; k++) put(mem[8'(a + k)], k == 0 ? gap : 1);
			else if (a[7:0] == 8'hFF)
				put(~ACK, gap); // this address stands for a failed bus access: no ack
			else begin // ack, data, ack
				put(ACK, gap);
				for (k = 0; k < nb; k++) begin
					get(v);
					mem[8'(a + k)] = v;
				end
				put(ACK, gap);
			end
		end
		3'h1: begin // pointer target or the pointer itself
			for (k = 0; k < nb; k++) put(i[3:2] == 2'h2 ? ptr[8*k +: 8] : mem[8'(ptr + k)], k == 0 ? gap : 1);
			if (i[3:2] == 2'h1) ptr = ptr + 24'(nb);
		end
		3'h3: begin // pointer write or data write, then ack
			if (i[3:2] == 2'h2) ptr = '0;
			for (k = 0; k < nb; k++) begin
				get(v);
				if (i[3:2] == 2'h2) ptr[8*k +: 8] = v;
				else mem[8'(ptr + k)] = v;
			end
			if (i[3:2] == 2'h1) ptr = ptr + 24'(nb);
			put(ACK, gap);
		end
		3'h4: put(cs[i[3:0]], gap); // exactly one byte
		3'h5: for (k = 0; k < nb; k++) begin // value width from size
			get(v);
			if (k == 0) rpt = v;
		end
		3'h6: begin // whole byte, no answer
			get(v);
			cs[i[3:0]] = v;
		end
		default: for (k = 0; k < (i[0] ? 16 : 8); k++) // key in or info out
			if (i[2]) put(8'h30 + 8'(k), k == 0 ? gap : 1);
			else get(v);
		endcase
	endtask

	// session: header, instruction, repeated runs
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		ptr      = '0;
		rpt      = 8'h00;
		n_chars  = 0;
		n_train  = 0;
		forever begin
			get(c);
			if (brk) rpt = 8'h00; // only a break ends a repeat
			else if (c == 8'h55) begin // header before each instruction
				n_train++;
				get(c);
				if (c[7:5] == 3'h5) op(c);
				else begin // later runs carry no header
					for (int r = 0; r <= int'(rpt); r++) op(c);
					rpt = 8'h00;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- test/debug_link_host_tb.sv
// self-checking bench for the debug link host controller
`timescale 1ns/10ps
`default_nettype none
module debug_link_host_tb;
	import debug_link_pkg::*;
	logic        clock   = 1'b0; // 100 MHz
	logic        rst_n   = 1'b0; // async, active low
	logic        psel    = 1'b0; // apb request
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata, rd;     // read data, last read
	logic        pready, pslverr, serr;
	logic        tx_valid, tx_ready, rx_valid, busy;
	link_tx_s    tx;             // host to device
	logic [7:0]  rx_data;        // device to host
	logic        slow    = 1'b0; // device answers slowly
	int          bad_count = 0;
	int          tests_run = 0;
	int          n0, n;          // snapshots and loop counts

	always #5 clock = ~clock;

	debug_link_host dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_tx_valid(tx_valid), .link_tx(tx), .link_tx_ready(tx_ready), .link_rx_valid(rx_valid),
		.link_rx_data(rx_data), .busy(busy));
	link_device_model dev_u (.clock(clock), .rst_n(rst_n), .tx_valid(tx_valid), .tx(tx),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .slow(slow));

	// counts, verdict, end of run
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0, 32'h1, "apb wait");
			finish_test();
		end
		rd      = prdata;
		serr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// load operation registers, start, wait for idle, read the result
	task automatic run(input logic [7:0] ins, input logic [31:0] ad, input logic [31:0] wd);
		apb(1'b1, OFS_INSTR, {24'h00_0000, ins});
		apb(1'b1, OFS_ADDR, ad);
		apb(1'b1, OFS_WDATA, wd);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (3) @(posedge clock);
		for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clock);
		if (n >= 4000) begin
			chk(32'h0, 32'h1, "busy wait");
			finish_test();
		end
		apb(1'b0, OFS_RDATA, 32'h0);
	endtask

	// reset values and an unmapped place
	task automatic t_regs();
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0, "status at reset");
		apb(1'b0, OFS_INSTR, 32'h0);
		chk(rd, 32'h0, "instr at reset");
		apb(1'b1, 8'h18, 32'h1);
		chk(32'(serr), 32'h1, "unmapped write");
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(serr), 32'h1, "unmapped read");
	endtask

	// direct store, then loads with one and three address bytes
	task automatic t_direct();
		run(8'h41, 32'h20, 32'h1234);
		chk(32'({dev_u.mem[8'h21], dev_u.mem[8'h20]}), 32'h1234, "direct store");
		n0 = dev_u.n_chars;
		run(8'h09, 32'h0120, 32'h0);
		chk(rd, 32'h1234, "direct load");
		chk(32'(dev_u.n_chars - n0), 32'h5, "three address bytes");
		run(8'hA0, 32'h0, 32'h1);
		run(8'h00, 32'h20, 32'h0);
		chk(rd, 32'h34, "first direct run");
		n0 = dev_u.n_chars;
		run(8'h00, 32'h21, 32'h0);
		chk(rd, 32'h12, "second direct run");
		chk(32'(dev_u.n_chars - n0), 32'h1, "address only");
	endtask

	// pointer, repeated post-increment store, pointer readback
	task automatic t_repeat();
		run(8'h68, 32'h50, 32'h0);
		chk(32'(dev_u.ptr), 32'h50, "pointer write");
		n0 = dev_u.n_train;
		run(8'hA0, 32'h0, 32'h2);
		for (int j = 0; j < 3; j++) run(8'h64, 32'h0, 32'h10 + j);
		chk(32'(dev_u.n_train - n0), 32'h2, "headers in run");
		for (int j = 0; j < 3; j++) chk(32'(dev_u.mem[8'h50 + j]), 32'h10 + j, "repeated store");
		run(8'h28, 32'h0, 32'h0);
		chk(rd, 32'h53, "pointer read");
		run(8'h68, 32'h50, 32'h0);
		run(8'h25, 32'h0, 32'h0);
		chk(rd, 32'h1110, "pointer target load");
		chk(32'(dev_u.ptr), 32'h52, "pointer advanced");
	endtask

	// control/status store and load
	task automatic t_cs();
		n0 = dev_u.n_chars;
		run(8'hC3, 32'h0, 32'h5A);
		chk(32'(dev_u.cs[3]), 32'h5A, "cs store");
		chk(32'(dev_u.n_chars - n0), 32'h3, "cs store chars");
		run(8'h83, 32'h0, 32'h0);
		chk(rd, 32'h5A, "cs load");
	endtask

	// info block and key
	task automatic t_key();
		run(8'hE5, 32'h0, 32'h0);
		chk(rd, 32'h3F3E_3D3C, "info block tail");
		n0 = dev_u.n_chars;
		run(8'hE0, 32'h0, 32'h0);
		chk(32'(dev_u.n_chars - n0), 32'hA, "key chars");
	endtask

	// send a break and wait until the device has taken it
	task automatic send_break();
		n0 = dev_u.n_chars;
		apb(1'b1, OFS_CTRL, 32'h2);
		for (n = 0; n < 200 && dev_u.n_chars == n0; n++) @(posedge clock);
		chk(32'(dev_u.brk), 32'h1, "break sent");
	endtask

	// reserved field refused, missing ack, repeat of repeat; a break after each, clearing checked after the first and last
	task automatic t_error();
		n0 = dev_u.n_chars;
		run(8'h4C, 32'h20, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'hA, 32'hA, "error and refused");
		chk(32'(dev_u.n_chars - n0), 32'h0, "nothing sent");
		send_break();
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'hA, 32'h0, "break clears");
		run(8'h40, 32'hFF, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'hE, 32'h6, "missing ack is an error");
		send_break();
		run(8'hA0, 32'h0, 32'h0);
		n0 = dev_u.n_chars;
		run(8'hA0, 32'h0, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'hA, 32'hA, "repeat of repeat refused");
		chk(32'(dev_u.n_chars - n0), 32'h0, "repeat not sent");
		send_break();
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h3E, 32'h0, "break clears repeat and errors");
	endtask

	// slow device answer
	task automatic t_slow();
		slow <= 1'b1;
		run(8'h01, 32'h20, 32'h0);
		chk(rd, 32'h1234, "slow load");
		slow <= 1'b0;
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_direct();
		t_repeat();
		t_cs();
		t_key();
		t_error();
		t_slow();
		finish_test();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		chk(32'h0, 32'h1, "run limit");
		finish_test();
	end
endmodule
`default_nettype wire
